/* bench/dtc_pins_model.sv */
// far-side pin sources: two event pins and the external prescale clock
// assumes the bench calls one task at a time; lines stand still between bursts
`timescale 1ns/1ns

module dtc_pins_model (
	input  wire logic sys_clk,
	output logic      event_pin_zero,
	output logic      event_pin_one,
	output logic      ext_clk_pin
);
	logic [1:0] ev_q = 2'b11;

	assign event_pin_zero = ev_q[0];
	assign event_pin_one  = ev_q[1];
	initial ext_clk_pin = 1'b0;

	// three clocks low and three high, at or above the two-clock sampling minimum
	task automatic pulses(input int t, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			ev_q[t] <= 1'b0;
			repeat (3) @(posedge sys_clk);
			ev_q[t] <= 1'b1;
			repeat (2) @(posedge sys_clk);
		end
	endtask

	task automatic edges(input int n);
		repeat (n) begin
			// low level held two clocks as well, so every rise is sampled cleanly
			repeat (2) @(posedge sys_clk);
			ext_clk_pin <= 1'b1;
			repeat (2) @(posedge sys_clk);
			ext_clk_pin <= 1'b0;
		end
	endtask
endmodule // dtc_pins_model

/* bench/dtc_timers_asserts.sv */
// concurrent checks on the register port and interrupt outputs of dtc_timers
// assumes one clock domain and the register map of dtc_pkg
`timescale 1ns/1ns

module dtc_timers_asserts
	import dtc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       vector_ack_zero,
	input wire logic       vector_ack_one,
	input wire logic       irq_req_zero,
	input wire logic       irq_req_one,
	input wire logic       timer_one_overflow
);
	logic [7:0] md_q;
	logic [1:0] ie_q;

	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// software's view of mode and enable, so checks need no internal probes
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			md_q <= DTC_RESET_BYTE;
			ie_q <= 2'h0;
		end else if (reg_wr && reg_addr == DTC_ADDR_MODE) begin
			md_q <= reg_wdata;
		end else if (reg_wr && reg_addr == DTC_ADDR_IRQ_EN) begin
			ie_q <= reg_wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	AST_RD_UNMAPPED: assert property ($past(reg_rd && reg_addr > 4'h8) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_MODE_READBACK: assert property ($past(reg_rd && reg_addr == 4'h5) |-> reg_rdata == $past(md_q))
		else $error("mode readback differs");
	AST_CLKSEL_MASK: assert property ($past(reg_rd && reg_addr == 4'h6) |-> reg_rdata[7:4] == 4'h0)
		else $error("clock select unused bits set");
	AST_IRQ0_MASK: assert property (irq_req_zero |-> $past(ie_q[0]))
		else $error("timer zero request while disabled");
	AST_IRQ1_MASK: assert property (irq_req_one |-> $past(ie_q[1]))
		else $error("timer one request while disabled");
	AST_IRQ0_FALL: assert property ($fell(irq_req_zero) |-> $past(vector_ack_zero) || $past(reg_wr, 2))
		else $error("timer zero request dropped without cause");
	AST_IRQ1_FALL: assert property ($fell(irq_req_one) |-> $past(vector_ack_one) || $past(reg_wr, 2))
		else $error("timer one request dropped without cause");

	COV_IRQ0: cover property (irq_req_zero);
	COV_IRQ1: cover property (irq_req_one);
	COV_OVF: cover property (timer_one_overflow);
endmodule // dtc_timers_asserts

bind dtc_timers dtc_timers_asserts dtc_timers_asserts_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.vector_ack_zero(vector_ack_zero), .vector_ack_one(vector_ack_one),
	.irq_req_zero(irq_req_zero), .irq_req_one(irq_req_one),
	.timer_one_overflow(timer_one_overflow)
);

/* bench/dtc_timers_tb.sv */
// self-checking bench for dtc_timers over its plain register port
// assumes dtc_pins_model drives the event and external clock pins
`timescale 1ns/1ns

module dtc_timers_tb;
	logic       sys_clk;
	logic       rst_n;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       ev0, ev1, ext, g0, g1, ack0, ack1, irq0, irq1, ovf;
	logic [7:0] d, e;
	logic [7:0] pre [3] = '{8'h08, 8'h18, 8'h02};
	int         n_mismatch = 0;
	int         checked = 0;

	dtc_timers dtc_timers_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.event_pin_zero(ev0), .event_pin_one(ev1), .gate_input_zero(g0),
		.gate_input_one(g1), .ext_clk_pin(ext), .vector_ack_zero(ack0),
		.vector_ack_one(ack1), .irq_req_zero(irq0), .irq_req_one(irq1),
		.timer_one_overflow(ovf)
	);
	dtc_pins_model dtc_pins_model_i (.sys_clk(sys_clk), .event_pin_zero(ev0),
		.event_pin_one(ev1), .ext_clk_pin(ext));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask

	task chk(input string s, input logic [7:0] seen, input logic [7:0] x);
		checked++;
		if (seen !== x) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", s, x, seen);
		end
	endtask

	task rc(input logic [3:0] a, input logic [7:0] x);
		rd(a);
		chk($sformatf("reg %h", a), d, x);
	endtask

	// gates open for exactly 2+w counting edges, closed by the gate bits
	task run(input logic [7:0] m, input int w);
		wr(4'h5, m);
		repeat (w) @(posedge sys_clk);
		wr(4'h5, m | 8'h88);
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// whole run is about 700 cycles; this allows over twenty times that
	initial begin
		#800000;
		n_mismatch++;
		finish_test;
	end

	initial begin
		{reg_wr, reg_rd, ack0, ack1, reg_addr, reg_wdata} = '0;
		g0 = 1'b1;
		g1 = 1'b1;
		rst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) rc(4'(i), 8'h00);
		wr(4'hF, 8'h5A);
		rc(4'hF, 8'h00);
		wr(4'h6, 8'hFF);
		rc(4'h6, 8'h0F);
		wr(4'h5, 8'hA5);
		rc(4'h5, 8'hA5);
		// 16-bit roll-over, interrupt, vector clear
		wr(4'h6, 8'h04);
		wr(4'h8, 8'h01);
		wr(4'h0, 8'hFE);
		wr(4'h1, 8'hFF);
		wr(4'h5, 8'h09);
		wr(4'h4, 8'h10);
		run(8'h01, 1);
		rc(4'h0, 8'h01);
		rc(4'h1, 8'h00);
		rc(4'h4, 8'h30);
		chk("irq0", {7'h0, irq0}, 8'h01);
		@(posedge sys_clk);
		ack0 <= 1'b1;
		@(posedge sys_clk);
		ack0 <= 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("irq0", {7'h0, irq0}, 8'h00);
		rc(4'h4, 8'h10);
		// 13-bit wrap with the request masked
		wr(4'h8, 8'h00);
		wr(4'h0, 8'hFE);
		wr(4'h1, 8'hFF);
		run(8'h00, 1);
		rc(4'h0, 8'hE1);
		rc(4'h1, 8'h00);
		rc(4'h4, 8'h30);
		chk("irq0", {7'h0, irq0}, 8'h00);
		// 8-bit auto-reload
		wr(4'h4, 8'h10);
		wr(4'h0, 8'hFE);
		wr(4'h1, 8'hA0);
		run(8'h02, 2);
		rc(4'h0, 8'hA2);
		rc(4'h1, 8'hA0);
		rc(4'h4, 8'h30);
		wr(4'h4, 8'h00);
		run(8'h02, 5);
		rc(4'h0, 8'hA2);
		wr(4'h4, 8'h10);
		run(8'h02, 0);
		rc(4'h0, 8'hA4);
		// falling edges on each event pin
		for (int t = 0; t < 2; t++) begin
			wr(4'(2 * t), 8'h00);
			wr(4'(2 * t + 1), 8'h00);
			wr(4'h5, 8'(8'h05 << (4 * t)));
			wr(4'h4, 8'(8'h10 << (2 * t)));
			dtc_pins_model_i.pulses(t, 5);
			repeat (8) @(posedge sys_clk);
			wr(4'h4, 8'h00);
			rc(4'(2 * t), 8'h05);
		end
		// active-high gate pin on timer one
		wr(4'h7, 8'h02);
		g1 <= 1'b0;
		wr(4'h6, 8'h08);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		// gate zero stays closed so the prescaler windows below start on the mode write
		wr(4'h5, 8'h98);
		wr(4'h4, 8'h40);
		g1 <= 1'b1;
		repeat (20) @(posedge sys_clk);
		g1 <= 1'b0;
		repeat (6) @(posedge sys_clk);
		wr(4'h4, 8'h00);
		rc(4'h2, 8'h14);
		// prescaler over a 96-edge window, then external clock / 8
		for (int s = 0; s < 3; s++) begin
			wr(4'h6, 8'(s));
			wr(4'h0, 8'h00);
			wr(4'h1, 8'h00);
			wr(4'h4, 8'h10);
			run(8'h01, 94);
			rc(4'h0, pre[s]);
		end
		wr(4'h6, 8'h03);
		wr(4'h0, 8'h00);
		wr(4'h5, 8'h01);
		dtc_pins_model_i.edges(16);
		repeat (8) @(posedge sys_clk);
		wr(4'h5, 8'h09);
		rc(4'h0, 8'h02);
		// split mode: timer one runs flagless, high byte owns its flag
		wr(4'h4, 8'h00);
		wr(4'h6, 8'h0C);
		wr(4'h8, 8'h02);
		wr(4'h2, 8'hFE);
		wr(4'h3, 8'hFF);
		wr(4'h0, 8'h33);
		wr(4'h1, 8'hFE);
		wr(4'h5, 8'h13);
		e = 8'h00;
		repeat (10) @(negedge sys_clk) e[0] = e[0] | ovf;
		chk("ovf", e, 8'h01);
		rc(4'h4, 8'h00);
		wr(4'h5, 8'h33);
		rd(4'h2);
		e = d;
		repeat (5) @(posedge sys_clk);
		rc(4'h2, e);
		wr(4'h4, 8'h40);
		@(posedge sys_clk);
		wr(4'h5, 8'h31);
		rc(4'h1, 8'h01);
		rc(4'h0, 8'h33);
		rc(4'h4, 8'hC0);
		chk("irq1", {7'h0, irq1}, 8'h01);
		@(posedge sys_clk);
		ack1 <= 1'b1;
		@(posedge sys_clk);
		ack1 <= 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("irq1", {7'h0, irq1}, 8'h00);
		rc(4'h4, 8'h40);
		wr(4'h4, 8'h00);
		repeat (3) @(negedge sys_clk);
		chk("irq1", {7'h0, irq1}, 8'h00);
		finish_test;
	end
endmodule // dtc_timers_tb

/* hw/dtc_pkg.sv */
// shared constants for the dual four-mode counter/timer block
// assumes a plain register port with 4-bit word index and 8-bit data
package dtc_pkg;

	// register indices on the plain register port
	localparam logic [3:0] DTC_ADDR_T0_LOW   = 4'h0;
	localparam logic [3:0] DTC_ADDR_T0_HIGH  = 4'h1;
	localparam logic [3:0] DTC_ADDR_T1_LOW   = 4'h2;
	localparam logic [3:0] DTC_ADDR_T1_HIGH  = 4'h3;
	localparam logic [3:0] DTC_ADDR_RUN_FLAG = 4'h4;
	localparam logic [3:0] DTC_ADDR_MODE     = 4'h5;
	localparam logic [3:0] DTC_ADDR_CLK_SEL  = 4'h6;
	localparam logic [3:0] DTC_ADDR_EXT_CFG  = 4'h7;
	localparam logic [3:0] DTC_ADDR_IRQ_EN   = 4'h8;

	// run/flag register fields
	localparam int DTC_RF_TF1 = 7;
	localparam int DTC_RF_TR1 = 6;
	localparam int DTC_RF_TF0 = 5;
	localparam int DTC_RF_TR0 = 4;

	// mode register fields
	localparam int DTC_MD_TIMER_ONE_PIN_GATING = 7;
	localparam int DTC_MD_CT1   = 6;
	localparam int DTC_MD_M1_HI = 5;
	localparam int DTC_MD_M1_LO = 4;
	localparam int DTC_MD_TIMER_ZERO_PIN_GATING = 3;
	localparam int DTC_MD_CT0   = 2;
	localparam int DTC_MD_M0_HI = 1;
	localparam int DTC_MD_M0_LO = 0;

	// clock select register fields
	localparam int DTC_CS_T1M    = 3;
	localparam int DTC_CS_T0M    = 2;
	localparam int DTC_CS_SCA_HI = 1;
	localparam int DTC_CS_SCA_LO = 0;
	localparam logic [7:0] DTC_CS_MASK = 8'h0F;

	// external config and interrupt enable fields
	localparam int DTC_EC_POL0 = 0;
	localparam int DTC_EC_POL1 = 1;
	localparam logic [7:0] DTC_EC_MASK = 8'h03;
	localparam int DTC_IE_ET0  = 0;
	localparam int DTC_IE_ET1  = 1;
	localparam logic [7:0] DTC_IE_MASK = 8'h03;

	localparam logic [7:0] DTC_RESET_BYTE = 8'h00;
	localparam logic [7:0] DTC_ONES_BYTE  = 8'hFF;
	localparam logic [4:0] DTC_ONES_FIVE  = 5'h1F;

	// prescaler: one counter of 48 yields the /4, /12 and /48 ticks
	localparam logic [5:0] DTC_PRE_LAST  = 6'h2F;
	localparam logic [5:0] DTC_PRE_TICK4 = 6'h03;
	localparam logic [5:0] DTC_PRE_DIV12 = 6'h0C;
	localparam logic [2:0] DTC_EXT_LAST  = 3'h7;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_8RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;

	typedef enum logic [1:0] {
		DTC_SCA_DIV12,
		DTC_SCA_DIV4,
		DTC_SCA_DIV48,
		DTC_SCA_EXT8
	} dtc_scale_t;

endpackage

/* hw/dtc_timers.sv */
// two counter/timers with four modes, prescaler, gating and overflow flags
// assumes one 25 MHz clock; pins arrive asynchronously and are synchronised here
//
// What this block does
// R1 - two 16-bit counts, byte-wise software access
// R2 - overflow requests gated by per-timer enable
// R3 - independent two-bit mode per timer
// R4 - mode 0: 13-bit, high byte plus low[4:0]
// R5 - mode 0 wrap sets overflow flag
// R6 - counter select counts event pin falling edges
// R7 - timer select: system or prescaled clock
// R8 - count only when run and gate allow
// R9 - second timer gated by second gate input
// R10 - run bit never clears the count
// R11 - software preloads count before enabling
// R12 - mode 1: full 16-bit counter
// R13 - mode 2: low byte reloads from high
// R14 - software preloads low byte in mode 2
// R15 - split mode: low byte uses timer zero controls
// R16 - split mode: high byte timer, second run bit
// R17 - split high overflow sets second flag
// R18 - split: second timer no pin, no flag
// R19 - split: second timer runs unless mode 3
// R20 - prescaler: /12, /4, /48, external /8
// R21 - flag holds until software or vector clears
// R22 - event levels held two clocks minimum
// R23 - split high byte uses zero clock select
// R24 - flag and reload in wrap cycle
`timescale 1ns/1ns

module dtc_timers
	import dtc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       event_pin_zero,
	input  wire logic       event_pin_one,
	input  wire logic       gate_input_zero,
	input  wire logic       gate_input_one,
	input  wire logic       ext_clk_pin,
	input  wire logic       vector_ack_zero,
	input  wire logic       vector_ack_one,
	output logic            irq_req_zero,
	output logic            irq_req_one,
	output logic            timer_one_overflow
);

	////////////////////////////////////////////////////////////////////////////
	// one counting step: returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input logic [7:0] hi, input logic [7:0] lo,
			input dtc_mode_t md);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		unique case (md)
			DTC_MODE_13BIT: begin
				// upper three low bits are left alone; readers must mask them
				if (lo[4:0] == DTC_ONES_FIVE) begin
					r[4:0] = 5'h00; // R4
					r[15:8] = hi + 8'h01;
					r[16] = (hi == DTC_ONES_BYTE); // R5
				end else begin
					r[4:0] = lo[4:0] + 5'h01;
				end
			end
			DTC_MODE_16BIT: begin
				r[16:0] = {1'b0, hi, lo} + 17'h00001; // R12
			end
			DTC_MODE_8RELOAD: begin
				if (lo == DTC_ONES_BYTE) begin
					r[7:0] = hi; // R13
					r[16] = 1'b1;
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			DTC_MODE_SPLIT: begin
				r[8:0] = {1'b0, lo} + 9'h001; // R15
				r[16] = r[8];
				r[15:8] = hi;
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; edge detectors read the second stage onward only
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic [4:0] pin_prev_q;
	wire  [4:0] pin_raw = {ext_clk_pin, gate_input_one, gate_input_zero,
			event_pin_one, event_pin_zero};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
			pin_prev_q <= 5'h00;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// two-clock minimum level on the pins makes every edge visible here
	wire ev_fall_zero = pin_prev_q[0] & ~pin_sync_q[0]; // R6 R22
	wire ev_fall_one  = pin_prev_q[1] & ~pin_sync_q[1]; // R6 R22
	wire ext_rise     = ~pin_prev_q[4] & pin_sync_q[4];

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] t0_low_q, t0_high_q, t1_low_q, t1_high_q;
	logic [7:0] mode_q, clk_sel_q, ext_cfg_q, irq_en_q;
	logic       tr0_q, tr1_q, tf0_q, tf1_q;
	logic [5:0] pre_cnt_q;
	logic [2:0] ext_cnt_q;
	logic       ext_tick_q;
	logic [7:0] rdata_q;

	dtc_mode_t  md0, md1;
	dtc_scale_t scale;
	assign md0   = dtc_mode_t'(mode_q[DTC_MD_M0_HI:DTC_MD_M0_LO]); // R3
	assign md1   = dtc_mode_t'(mode_q[DTC_MD_M1_HI:DTC_MD_M1_LO]); // R3
	assign scale = dtc_scale_t'(clk_sel_q[DTC_CS_SCA_HI:DTC_CS_SCA_LO]);

	////////////////////////////////////////////////////////////////////////////
	// prescaler
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pre_cnt_q  <= 6'h00;
			ext_cnt_q  <= 3'h0;
			ext_tick_q <= 1'b0;
		end else begin
			pre_cnt_q  <= (pre_cnt_q == DTC_PRE_LAST) ? 6'h00 : pre_cnt_q + 6'h01;
			ext_tick_q <= ext_rise && (ext_cnt_q == DTC_EXT_LAST);
			if (ext_rise)
				ext_cnt_q <= ext_cnt_q + 3'h1;
		end
	end

	wire pre_cnt_next_zero = (pre_cnt_q == DTC_PRE_LAST);
	wire tick_div4  = (pre_cnt_q[1:0] == DTC_PRE_TICK4[1:0]);
	wire tick_div12 = ((pre_cnt_q + 6'h01) == DTC_PRE_DIV12)
			|| ((pre_cnt_q + 6'h01) == (DTC_PRE_DIV12 + DTC_PRE_DIV12))
			|| ((pre_cnt_q + 6'h01) == (DTC_PRE_DIV12 + DTC_PRE_DIV12 + DTC_PRE_DIV12))
			|| pre_cnt_next_zero;
	logic pre_tick;
	always_comb begin
		unique case (scale) // R20
			DTC_SCA_DIV12: pre_tick = tick_div12;
			DTC_SCA_DIV4:  pre_tick = tick_div4;
			DTC_SCA_DIV48: pre_tick = pre_cnt_next_zero;
			DTC_SCA_EXT8:  pre_tick = ext_tick_q;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// count enables and ticks
	wire split = (md0 == DTC_MODE_SPLIT);
	wire gate_act_zero = ~(pin_sync_q[2] ^ ext_cfg_q[DTC_EC_POL0]);
	wire gate_act_one  = ~(pin_sync_q[3] ^ ext_cfg_q[DTC_EC_POL1]);
	wire run0 = tr0_q & (~mode_q[DTC_MD_TIMER_ZERO_PIN_GATING] | gate_act_zero); // R8 R10
	// outside split mode timer one's mode 3 simply holds the count
	wire run1 = split ? (md1 != DTC_MODE_SPLIT) // R19
			: (tr1_q & (~mode_q[DTC_MD_TIMER_ONE_PIN_GATING] | gate_act_one) // R8 R9
			& (md1 != DTC_MODE_SPLIT));
	wire int_tick0 = clk_sel_q[DTC_CS_T0M] | pre_tick; // R7
	wire int_tick1 = clk_sel_q[DTC_CS_T1M] | pre_tick; // R7
	wire tick0 = run0 & (mode_q[DTC_MD_CT0] ? ev_fall_zero : int_tick0); // R6 R15
	wire tick1 = run1 & ((mode_q[DTC_MD_CT1] && !split) ? ev_fall_one : int_tick1); // R18
	wire tick0_high = split & tr1_q & int_tick0; // R16 R23

	wire [16:0] step0 = dtc_step(t0_high_q, t0_low_q, md0);
	wire [16:0] step1 = dtc_step(t1_high_q, t1_low_q, md1);
	wire [8:0]  step0_hi = {1'b0, t0_high_q} + 9'h001;

	wire ovf0      = tick0 & step0[16];
	wire ovf1      = tick1 & step1[16];
	wire ovf0_high = tick0_high & step0_hi[8];
	wire set_tf0   = ovf0; // R5 R24
	wire set_tf1   = split ? ovf0_high : ovf1; // R17 R18

	////////////////////////////////////////////////////////////////////////////
	// register port decode
	wire wr_t0l = reg_wr && (reg_addr == DTC_ADDR_T0_LOW);
	wire wr_t0h = reg_wr && (reg_addr == DTC_ADDR_T0_HIGH);
	wire wr_t1l = reg_wr && (reg_addr == DTC_ADDR_T1_LOW);
	wire wr_t1h = reg_wr && (reg_addr == DTC_ADDR_T1_HIGH);
	wire wr_rf  = reg_wr && (reg_addr == DTC_ADDR_RUN_FLAG);
	wire wr_md  = reg_wr && (reg_addr == DTC_ADDR_MODE);
	wire wr_cs  = reg_wr && (reg_addr == DTC_ADDR_CLK_SEL);
	wire wr_ec  = reg_wr && (reg_addr == DTC_ADDR_EXT_CFG);
	wire wr_ie  = reg_wr && (reg_addr == DTC_ADDR_IRQ_EN);

	wire [7:0] run_flag_view = {tf1_q, tr1_q, tf0_q, tr0_q, 4'h0};
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			DTC_ADDR_T0_LOW:   rd_mux = t0_low_q;
			DTC_ADDR_T0_HIGH:  rd_mux = t0_high_q;
			DTC_ADDR_T1_LOW:   rd_mux = t1_low_q;
			DTC_ADDR_T1_HIGH:  rd_mux = t1_high_q;
			DTC_ADDR_RUN_FLAG: rd_mux = run_flag_view;
			DTC_ADDR_MODE:     rd_mux = mode_q;
			DTC_ADDR_CLK_SEL:  rd_mux = clk_sel_q;
			DTC_ADDR_EXT_CFG:  rd_mux = ext_cfg_q;
			DTC_ADDR_IRQ_EN:   rd_mux = irq_en_q;
			default:           rd_mux = DTC_RESET_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers and read data
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_q    <= DTC_RESET_BYTE;
			clk_sel_q <= DTC_RESET_BYTE;
			ext_cfg_q <= DTC_RESET_BYTE;
			irq_en_q  <= DTC_RESET_BYTE;
			tr0_q     <= 1'b0;
			tr1_q     <= 1'b0;
			rdata_q   <= DTC_RESET_BYTE;
		end else begin
			if (wr_md)
				mode_q <= reg_wdata;
			if (wr_cs)
				clk_sel_q <= reg_wdata & DTC_CS_MASK;
			if (wr_ec)
				ext_cfg_q <= reg_wdata & DTC_EC_MASK;
			if (wr_ie)
				irq_en_q <= reg_wdata & DTC_IE_MASK;
			if (wr_rf) begin
				tr0_q <= reg_wdata[DTC_RF_TR0]; // R10
				tr1_q <= reg_wdata[DTC_RF_TR1];
			end
			rdata_q <= reg_rd ? rd_mux : DTC_RESET_BYTE;
		end
	end
	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// overflow flags: a hardware set beats any clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tf0_q <= 1'b0;
			tf1_q <= 1'b0;
		end else begin
			if (set_tf0)
				tf0_q <= 1'b1; // R21 R24
			else if (vector_ack_zero)
				tf0_q <= 1'b0; // R21
			else if (wr_rf)
				tf0_q <= reg_wdata[DTC_RF_TF0];
			if (set_tf1)
				tf1_q <= 1'b1; // R21 R24
			else if (vector_ack_one)
				tf1_q <= 1'b0; // R21
			else if (wr_rf)
				tf1_q <= reg_wdata[DTC_RF_TF1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// count registers: a software byte write wins over a count of that byte
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			t0_low_q  <= DTC_RESET_BYTE;
			t0_high_q <= DTC_RESET_BYTE;
			t1_low_q  <= DTC_RESET_BYTE;
			t1_high_q <= DTC_RESET_BYTE;
		end else begin
			if (wr_t0l)
				t0_low_q <= reg_wdata; // R1
			else if (tick0)
				t0_low_q <= step0[7:0];
			if (wr_t0h)
				t0_high_q <= reg_wdata; // R1
			else if (tick0_high)
				t0_high_q <= step0_hi[7:0]; // R16
			else if (tick0 && !split)
				t0_high_q <= step0[15:8];
			if (wr_t1l)
				t1_low_q <= reg_wdata; // R1
			else if (tick1)
				t1_low_q <= step1[7:0];
			if (wr_t1h)
				t1_high_q <= reg_wdata; // R1
			else if (tick1)
				t1_high_q <= step1[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	logic irq0_q, irq1_q, ovf1_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq0_q <= 1'b0;
			irq1_q <= 1'b0;
			ovf1_q <= 1'b0;
		end else begin
			irq0_q <= (tf0_q | set_tf0) & irq_en_q[DTC_IE_ET0] & ~(vector_ack_zero & ~set_tf0); // R2
			irq1_q <= (tf1_q | set_tf1) & irq_en_q[DTC_IE_ET1] & ~(vector_ack_one & ~set_tf1); // R2
			ovf1_q <= ovf1; // R18
		end
	end
	assign irq_req_zero       = irq0_q;
	assign irq_req_one        = irq1_q;
	assign timer_one_overflow = ovf1_q;

endmodule // dtc_timers
